// ==== inc/mac_dma_pkg.sv ====
// constants, register map and descriptor layout of the descriptor dma
// assumes one clock domain shared by bus, memory port and mac core
// Overview of operation
// - rx length field low bits, fcs kept or dropped, jumbo adds bit 13
// - rx base loaded before receive enable; writes ignored while enabled
// - reading rx base returns current descriptor pointer
// - accepted frame written to current buffer; error reclaims buffer
// - rx pointer steps two words per buffer, wraps to base on wrap
// - consumed rx buffer gets used bit 0 set in word 0
// - used rx descriptor is not taken and rx pointer stays; sets not-available flag and event
// - tx frame 1 to 16384 bytes, zero-length buffers, max 128 buffers; first buffer is checked against the previous frame's byte and buffer counts
// - tx descriptor is byte address word then control/status word
// - auto crc pads to 64 bytes; no-crc frames get no pad
// - tx needs used bit 31 clear; status and used written after send
// - tx bits 29:20 report errors; wrap bit 30 on any buffer
// - tx base writes only while disabled or halted
// - halt keeps tx pointer, restart continues after last sent frame
// - tx disable resets tx pointer to base; rx disable does not
// - start command at control bit 9; repeat while running allowed
// - halt on used fetch, error or halt bit 10; halt waits frame end
// - pause frame suspends tx when pause handling is enabled
// - tx active status bit 3 set by start, cleared by stop causes
// - used descriptor mid-frame is an error: stop, error out, bad fcs
// - restart after error resumes at first buffer of that frame
// - rx status bit 15 end of frame, bit 14 start of frame
package mac_dma_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] CTRL_ADDR = 6'h00;
    localparam logic [5:0] CFG_ADDR = 6'h04;
    localparam logic [5:0] TXSTAT_ADDR = 6'h14;
    localparam logic [5:0] RXQ_ADDR = 6'h18;
    localparam logic [5:0] TXQ_ADDR = 6'h1C;
    localparam logic [5:0] RXSTAT_ADDR = 6'h20;
    localparam int CTRL_RX_EN = 2;
    localparam int CTRL_TX_EN = 3;
    localparam int CTRL_START = 9;
    localparam int CTRL_HALT = 10;
    localparam int CFG_JUMBO = 3;
    localparam int CFG_PAUSE = 13;
    localparam int CFG_FCS_DISC = 17;
    localparam int TXS_USED = 0;
    localparam int TXS_ACTIVE = 3;
    localparam int TXS_ERR = 4;
    localparam int RXS_BNA = 0;
    localparam int RXD_USED = 0;
    localparam int RXD_WRAP = 1;
    localparam int RXD_JLEN = 13;
    localparam int RXD_SOF = 14;
    localparam int RXD_EOF = 15;
    localparam int TXD_USED = 31;
    localparam int TXD_WRAP = 30;
    localparam int TXD_NOCRC = 16;
    localparam int TXD_LAST = 15;
    localparam int TXD_LEN_W = 14;
    localparam int TX_ERR_W = 10;
    localparam logic [31:0] DESC_STEP = 32'h0000_0008;
    localparam logic [31:0] WORD1_OFS = 32'h0000_0004;
    localparam logic [13:0] FCS_BYTES = 14'h0004;
    localparam logic [14:0] TX_MAX_BYTES = 15'h4000;
    localparam logic [7:0] TX_MAX_BUFS = 8'h80;
    localparam logic [6:0] MIN_FRAME = 7'h40;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX_F1 = 3'b001,
        ST_TX_F0 = 3'b011,
        ST_TX_GIVE = 3'b010,
        ST_TX_WB = 3'b110,
        ST_RX_F = 3'b111,
        ST_RX_WB0 = 3'b101,
        ST_RX_WB1 = 3'b100
    } dma_state_e;
endpackage

// ==== hw/mac_descriptor_dma.sv ====
// descriptor dma for the mac core: rx and tx queue walking
// assumes memory port and mac core run on sys_clk; memory acks in one pulse
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module mac_descriptor_dma
    import mac_dma_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // memory master
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // rx side of mac core
    input wire logic rx_accept,
    input wire logic rx_buf_end,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_error,
    input wire logic [13:0] rx_len,
    output logic rx_buf_valid,
    output logic [31:0] rx_buf_addr,
    output logic rx_no_buf,
    output logic bna_event,
    // tx side of mac core
    input wire logic tx_buf_ack,
    input wire logic tx_frame_done,
    input wire logic [TX_ERR_W-1:0] tx_frame_status,
    input wire logic pause_active,
    output logic tx_buf_valid,
    output logic [31:0] tx_buf_addr,
    output logic [TXD_LEN_W-1:0] tx_buf_len,
    output logic tx_buf_last,
    output logic tx_buf_first,
    output logic tx_pad_en,
    output logic [6:0] tx_min_len,
    output logic tx_error_out
);
    dma_state_e state;
    logic rx_en, tx_en;
    logic [31:0] cfg, rx_base, tx_base, rx_ptr, tx_ptr, frame_start;
    logic [31:0] rx_word0, rx_status, tx_ctrl, first_ctrl;
    logic rx_req_pend, rx_end_pend, tx_done_pend, rx_end_err;
    logic [TX_ERR_W-1:0] tx_done_stat;
    logic tx_active_flag, halt_req, in_frame, last_given;
    logic st_used, st_err, st_bna;
    logic [7:0] buf_cnt;
    logic [14:0] byte_cnt;
    // bus decode
    wire wr_ctrl = reg_wr && reg_addr == CTRL_ADDR;
    wire wr_cfg = reg_wr && reg_addr == CFG_ADDR;
    wire wr_txs = reg_wr && reg_addr == TXSTAT_ADDR;
    wire wr_rxs = reg_wr && reg_addr == RXSTAT_ADDR;
    wire wr_rxq = reg_wr && reg_addr == RXQ_ADDR;
    wire wr_txq = reg_wr && reg_addr == TXQ_ADDR;
    wire network_control_reg = wr_ctrl;
    wire tx_start_cmd = network_control_reg && reg_wdata[CTRL_START];
    wire tx_halt_cmd = network_control_reg && reg_wdata[CTRL_HALT];
    wire next_tx_en = wr_ctrl ? reg_wdata[CTRL_TX_EN] : tx_en;
    wire rxq_take = wr_rxq && !rx_en;
    wire txq_take = wr_txq && (!tx_en || (!tx_active_flag && !in_frame));
    wire [31:0] txs_rd = {27'h0, st_err, tx_active_flag, 2'b00, st_used};
    wire [31:0] ctrl_rd = {28'h0, tx_en, rx_en, 2'b00};
    wire [31:0] rd_mux =
        reg_addr == CTRL_ADDR ? ctrl_rd :
        reg_addr == CFG_ADDR ? cfg :
        reg_addr == TXSTAT_ADDR ? txs_rd :
        reg_addr == RXQ_ADDR ? rx_ptr :
        reg_addr == TXQ_ADDR ? tx_base :
        reg_addr == RXSTAT_ADDR ? {31'h0, st_bna} : 32'h0000_0000;
    // memory handshake and descriptor fields
    wire done = mem_req && mem_ack;
    wire rx_used = mem_rdata[RXD_USED];
    wire tx_used = mem_rdata[TXD_USED];
    wire [TXD_LEN_W-1:0] d_len = mem_rdata[TXD_LEN_W-1:0];
    // frame size and buffer count limits
    wire [14:0] sum_len = byte_cnt + {1'b0, d_len};
    wire over = sum_len > TX_MAX_BYTES || buf_cnt == TX_MAX_BUFS;
    wire paused = cfg[CFG_PAUSE] && pause_active;
    wire tx_go = tx_en && tx_active_flag && !tx_done_pend && !tx_buf_valid
        && (in_frame ? !last_given : (!halt_req && !paused));
    // length with or without fcs, jumbo bit 13
    wire [13:0] len_adj = cfg[CFG_FCS_DISC] ? rx_len - FCS_BYTES : rx_len;
    wire len_hi = cfg[CFG_JUMBO] & len_adj[13];
    wire [31:0] rx_stat_word = {16'h0, rx_eof, rx_sof, len_hi, len_adj[12:0]};
    wire [31:0] rx_next = rx_word0[RXD_WRAP] ? rx_base : rx_ptr + DESC_STEP;
    wire [31:0] tx_next = tx_ctrl[TXD_WRAP] ? tx_base : tx_ptr + DESC_STEP;
    // status, wrap and used into first buffer word 1
    wire [31:0] tx_wb_word = {1'b1, first_ctrl[TXD_WRAP], tx_done_stat,
        first_ctrl[19:0]};
    // nonzero error field ends the run
    wire tx_fail = |tx_done_stat;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rx_en <= 1'b0;
            tx_en <= 1'b0;
            cfg <= CFG_RST;
            rx_base <= 32'h0000_0000;
            tx_base <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl)
                rx_en <= reg_wdata[CTRL_RX_EN];
            tx_en <= next_tx_en;
            if (wr_cfg)
                cfg <= reg_wdata;
            if (rxq_take)
                rx_base <= {reg_wdata[31:2], 2'b00};
            if (txq_take)
                tx_base <= reg_wdata;
        end
    end

    // sticky status: a hardware set beats a same-cycle write-one clear
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_used <= 1'b0;
            st_err <= 1'b0;
            st_bna <= 1'b0;
        end
        else
        begin
            if (state == ST_TX_F1 && done && tx_used)
                st_used <= 1'b1;
            else if (wr_txs && reg_wdata[TXS_USED])
                st_used <= 1'b0;
            if (tx_error_out)
                st_err <= 1'b1;
            else if (wr_txs && reg_wdata[TXS_ERR])
                st_err <= 1'b0;
            if (bna_event)
                st_bna <= 1'b1;
            else if (wr_rxs && reg_wdata[RXS_BNA])
                st_bna <= 1'b0;
        end
    end

    // pending events from the mac core
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rx_req_pend <= 1'b0;
            rx_end_pend <= 1'b0;
            rx_end_err <= 1'b0;
            tx_done_pend <= 1'b0;
            tx_done_stat <= '0;
        end
        else
        begin
            if (rx_accept && rx_en)
                rx_req_pend <= 1'b1;
            else if (state == ST_RX_F && done)
                rx_req_pend <= 1'b0;
            if (rx_buf_end && rx_buf_valid)
            begin
                rx_end_pend <= 1'b1;
                rx_end_err <= rx_error;
            end
            else if ((state == ST_RX_WB1 && done) || (state == ST_IDLE && rx_end_err))
                rx_end_pend <= 1'b0;
            if (tx_frame_done && in_frame)
            begin
                tx_done_pend <= 1'b1;
                tx_done_stat <= tx_frame_status;
            end
            else if ((state == ST_TX_WB && done) || !tx_en)
                tx_done_pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            rx_ptr <= 32'h0000_0000;
            rx_word0 <= 32'h0000_0000;
            rx_status <= 32'h0000_0000;
            rx_buf_valid <= 1'b0;
            rx_buf_addr <= 32'h0000_0000;
            rx_no_buf <= 1'b0;
            bna_event <= 1'b0;
            tx_ptr <= 32'h0000_0000;
            frame_start <= 32'h0000_0000;
            tx_ctrl <= 32'h0000_0000;
            first_ctrl <= 32'h0000_0000;
            tx_active_flag <= 1'b0;
            halt_req <= 1'b0;
            in_frame <= 1'b0;
            last_given <= 1'b0;
            buf_cnt <= 8'h00;
            byte_cnt <= 15'h0000;
            tx_buf_valid <= 1'b0;
            tx_buf_addr <= 32'h0000_0000;
            tx_buf_len <= '0;
            tx_buf_last <= 1'b0;
            tx_buf_first <= 1'b0;
            tx_pad_en <= 1'b0;
            tx_min_len <= MIN_FRAME;
            tx_error_out <= 1'b0;
        end
        else
        begin
            rx_no_buf <= 1'b0;
            bna_event <= 1'b0;
            tx_error_out <= 1'b0;
            if (rx_buf_end && rx_buf_valid)
                rx_status <= rx_stat_word;
            if (rxq_take)
                rx_ptr <= {reg_wdata[31:2], 2'b00};
            // start sets active, repeat is harmless
            if (tx_start_cmd && next_tx_en)
                tx_active_flag <= 1'b1;
            // halt request waits for frame end
            if (tx_halt_cmd)
                halt_req <= 1'b1;
            // halt write clears active outside a frame
            if (halt_req && !in_frame)
            begin
                tx_active_flag <= 1'b0;
                halt_req <= 1'b0;
            end
            if (txq_take)
                tx_ptr <= reg_wdata;
            if (tx_buf_valid && tx_buf_ack)
                tx_buf_valid <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    if (rx_end_pend && rx_end_err)
                    begin
                        rx_buf_valid <= 1'b0;
                    end
                    else if (rx_end_pend)
                    begin
                        state <= ST_RX_WB0;
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= rx_ptr;
                        mem_wdata <= rx_word0 | 32'h0000_0001;
                    end
                    else if (rx_req_pend && !rx_buf_valid)
                    begin
                        state <= ST_RX_F;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= rx_ptr;
                    end
                    else if (tx_done_pend)
                    begin
                        state <= ST_TX_WB;
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= frame_start + WORD1_OFS;
                        mem_wdata <= tx_wb_word;
                    end
                    else if (tx_go)
                    begin
                        state <= ST_TX_F1;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= tx_ptr + WORD1_OFS;
                    end
                end
                ST_RX_F:
                begin
                    if (done)
                    begin
                        mem_req <= 1'b0;
                        state <= ST_IDLE;
                        rx_word0 <= mem_rdata;
                        if (rx_used)
                        begin
                            rx_no_buf <= 1'b1;
                            bna_event <= 1'b1;
                        end
                        else
                        begin
                            rx_buf_valid <= 1'b1;
                            rx_buf_addr <= {mem_rdata[31:2], 2'b00};
                        end
                    end
                end
                ST_RX_WB0:
                begin
                    if (done)
                    begin
                        state <= ST_RX_WB1;
                        mem_addr <= rx_ptr + WORD1_OFS;
                        mem_wdata <= rx_status;
                    end
                end
                ST_RX_WB1:
                begin
                    if (done)
                    begin
                        mem_req <= 1'b0;
                        state <= ST_IDLE;
                        rx_buf_valid <= 1'b0;
                        rx_ptr <= rx_next;
                    end
                end
                ST_TX_F1:
                begin
                    if (done)
                    begin
                        tx_ctrl <= mem_rdata;
                        if (tx_used || over)
                        begin
                            mem_req <= 1'b0;
                            state <= ST_IDLE;
                            // used fetch or error clears active
                            tx_active_flag <= 1'b0;
                            halt_req <= 1'b0;
                            if (in_frame)
                            begin
                                tx_error_out <= 1'b1;
                                in_frame <= 1'b0;
                                tx_ptr <= frame_start;
                            end
                            else if (over)
                                tx_error_out <= 1'b1;
                        end
                        else
                        begin
                            state <= ST_TX_F0;
                            mem_addr <= tx_ptr;
                            if (!in_frame)
                            begin
                                in_frame <= 1'b1;
                                frame_start <= tx_ptr;
                                first_ctrl <= mem_rdata;
                                buf_cnt <= 8'h01;
                                byte_cnt <= {1'b0, d_len};
                                tx_pad_en <= !mem_rdata[TXD_NOCRC];
                            end
                            else
                            begin
                                buf_cnt <= buf_cnt + 8'h01;
                                byte_cnt <= sum_len;
                            end
                        end
                    end
                end
                ST_TX_F0:
                begin
                    if (done)
                    begin
                        mem_req <= 1'b0;
                        state <= ST_TX_GIVE;
                        tx_buf_valid <= 1'b1;
                        tx_buf_addr <= mem_rdata;
                        tx_buf_len <= tx_ctrl[TXD_LEN_W-1:0];
                        tx_buf_last <= tx_ctrl[TXD_LAST];
                        tx_buf_first <= buf_cnt == 8'h01;
                        last_given <= tx_ctrl[TXD_LAST];
                        tx_ptr <= tx_next;
                    end
                end
                ST_TX_GIVE:
                begin
                    state <= ST_IDLE;
                end
                ST_TX_WB:
                begin
                    if (done)
                    begin
                        mem_req <= 1'b0;
                        state <= ST_IDLE;
                        in_frame <= 1'b0;
                        last_given <= 1'b0;
                        if (tx_fail)
                        begin
                            tx_active_flag <= 1'b0;
                            halt_req <= 1'b0;
                            tx_ptr <= frame_start;
                        end
                    end
                end
            endcase
            // disable returns tx pointer to base
            if (!next_tx_en)
            begin
                tx_active_flag <= 1'b0;
                halt_req <= 1'b0;
                in_frame <= 1'b0;
                last_given <= 1'b0;
                tx_buf_valid <= 1'b0;
                tx_ptr <= txq_take ? reg_wdata : tx_base;
            end
        end
    end
endmodule

// ==== bench/mac_descriptor_dma_asserts.sv ====
// checker for the descriptor dma: port-level timing relations
// assumes a bind onto mac_descriptor_dma, one sys_clk domain
`timescale 1ns/10ps
module mac_dma_checker
    import mac_dma_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // memory master
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_addr,
    // mac core side
    input wire logic rx_buf_valid,
    input wire logic [31:0] rx_buf_addr,
    input wire logic rx_no_buf,
    input wire logic bna_event,
    input wire logic tx_buf_valid,
    input wire logic tx_buf_ack,
    input wire logic [31:0] tx_buf_addr,
    input wire logic [13:0] tx_buf_len,
    input wire logic [6:0] tx_min_len
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_cmd_read_zero: assert property (reg_rd && reg_addr == CTRL_ADDR |=>
        reg_rdata[CTRL_START] == 1'h0 && reg_rdata[CTRL_HALT] == 1'h0)
        else $error("command bits read back nonzero");
    a_min_len_fixed: assert property (tx_min_len == MIN_FRAME)
        else $error("pad length not 64");
    a_bna_pair: assert property (rx_no_buf == bna_event)
        else $error("no-buffer and event differ");
    a_bna_pulse: assert property (rx_no_buf |-> !rx_buf_valid ##1 !rx_no_buf)
        else $error("used buffer handed out or flag held");
    a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved");
    a_rx_buf_align: assert property (rx_buf_valid |-> rx_buf_addr[1:0] == 2'h0)
        else $error("rx buffer not word aligned");
    a_tx_buf_hold: assert property (tx_buf_valid && !tx_buf_ack |=>
        tx_buf_valid && $stable(tx_buf_addr) && $stable(tx_buf_len))
        else $error("tx buffer offer changed before ack");
    c_no_buf: cover property (rx_no_buf);
    c_tx_buf: cover property (tx_buf_valid && tx_buf_ack);
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind mac_descriptor_dma mac_dma_checker u_mac_dma_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr),
    .rx_buf_valid(rx_buf_valid), .rx_buf_addr(rx_buf_addr), .rx_no_buf(rx_no_buf),
    .bna_event(bna_event), .tx_buf_valid(tx_buf_valid), .tx_buf_ack(tx_buf_ack),
    .tx_buf_addr(tx_buf_addr), .tx_buf_len(tx_buf_len), .tx_min_len(tx_min_len)
);

// ==== bench/desc_mem_model.sv ====
// descriptor memory: 64 words, acks each held request after a delay
// assumes requests held until ack; bench preloads the lists
`timescale 1ns/10ps
module desc_mem_model (
    // clock, reset and pacing
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic slow,
    // memory slave
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:63];
    logic [2:0] wait_cnt;
    assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
    always @(posedge sys_clk)
    begin
        if (sys_rst || !mem_req || mem_ack)
        begin
            mem_ack <= 1'h0;
            wait_cnt <= 3'h0;
        end
        else if (wait_cnt == (slow ? 3'h3 : 3'h0))
        begin
            mem_ack <= 1'h1;
            if (mem_we)
                mem[mem_addr[7:2]] <= mem_wdata;
        end
        else
            wait_cnt <= wait_cnt + 3'h1;
    end
endmodule

// ==== bench/tb_mac_descriptor_dma.sv ====
// testbench: register tasks, mac side stimulus, memory model
// assumes checker bound from its own file
`timescale 1ns/10ps
module tb_mac_descriptor_dma;
    import mac_dma_pkg::*;
    logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, slow = 1'h0;
    logic [5:0] reg_addr = 6'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] rx_buf_addr, tx_buf_addr;
    logic mem_req, mem_we, mem_ack, rx_buf_valid, rx_no_buf, bna_event, tx_buf_valid;
    logic tx_buf_last, tx_buf_first, tx_pad_en, tx_error_out;
    logic rx_accept = 1'h0, rx_buf_end = 1'h0, rx_sof = 1'h0, rx_eof = 1'h0;
    logic rx_error = 1'h0, tx_buf_ack = 1'h0, tx_frame_done = 1'h0, pause_active = 1'h0;
    logic [13:0] rx_len = 14'h0, tx_buf_len;
    logic [9:0] tx_frame_status = 10'h0;
    logic [6:0] tx_min_len;
    int miscompares = 0, check_count = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    mac_descriptor_dma u_mac_descriptor_dma (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .rx_accept(rx_accept), .rx_buf_end(rx_buf_end), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_error(rx_error), .rx_len(rx_len), .rx_buf_valid(rx_buf_valid),
        .rx_buf_addr(rx_buf_addr), .rx_no_buf(rx_no_buf), .bna_event(bna_event),
        .tx_buf_ack(tx_buf_ack), .tx_frame_done(tx_frame_done),
        .tx_frame_status(tx_frame_status), .pause_active(pause_active),
        .tx_buf_valid(tx_buf_valid), .tx_buf_addr(tx_buf_addr), .tx_buf_len(tx_buf_len),
        .tx_buf_last(tx_buf_last), .tx_buf_first(tx_buf_first), .tx_pad_en(tx_pad_en),
        .tx_min_len(tx_min_len), .tx_error_out(tx_error_out));
    desc_mem_model u_desc_mem_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    task acc;
        @(posedge sys_clk);
        rx_accept <= 1'h1;
        @(posedge sys_clk);
        rx_accept <= 1'h0;
    endtask
    task rx_frame(input logic [31:0] ba, input logic [13:0] n);
        acc;
        wait (rx_buf_valid === 1'h1);
        #1 chk(rx_buf_addr, ba);
        @(posedge sys_clk);
        {rx_buf_end, rx_sof, rx_eof, rx_len} <= {3'h7, n};
        @(posedge sys_clk);
        {rx_buf_end, rx_sof, rx_eof} <= 3'h0;
        repeat (12) @(posedge sys_clk);
    endtask
    task tx_start;
        wr(CTRL_ADDR, 32'h8);
        wr(CTRL_ADDR, 32'h208);
        wait (tx_buf_valid === 1'h1);
        #1 chk(tx_buf_addr, 32'h300);
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test;
        end
    end
    initial
    begin
        for (int i = 0; i < 64; i++)
            u_desc_mem_model.mem[i] = 32'h0;
        u_desc_mem_model.mem[16] = 32'h100;
        u_desc_mem_model.mem[18] = 32'h202;
        u_desc_mem_model.mem[32] = 32'h300;
        u_desc_mem_model.mem[33] = 32'h8014;
        u_desc_mem_model.mem[35] = 32'h8000_0000;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rd(TXSTAT_ADDR, 32'h0);
        wr(RXQ_ADDR, 32'h40);
        wr(CFG_ADDR, 32'h0002_0000);
        wr(CTRL_ADDR, 32'h4);
        rd(CTRL_ADDR, 32'h4);
        wr(RXQ_ADDR, 32'h80);
        rd(RXQ_ADDR, 32'h40);
        rx_frame(32'h100, 14'h64);
        chk(u_desc_mem_model.mem[16], 32'h101);
        chk(u_desc_mem_model.mem[17], 32'hC060);
        rd(RXQ_ADDR, 32'h48);
        wr(CFG_ADDR, 32'h0002_0008);
        rx_frame(32'h200, 14'h2010);
        chk(u_desc_mem_model.mem[18], 32'h203);
        chk(u_desc_mem_model.mem[19], 32'hE00C);
        rd(RXQ_ADDR, 32'h40);
        acc;
        wait (rx_no_buf === 1'h1);
        #1 chk(bna_event, 1'h1);
        rd(RXSTAT_ADDR, 32'h1);
        slow <= 1'h1;
        wr(TXQ_ADDR, 32'h80);
        tx_start;
        chk({tx_buf_first, tx_buf_last, tx_pad_en, 15'h0, tx_buf_len}, 32'hE000_0014);
        rd(TXSTAT_ADDR, 32'h8);
        wr(TXQ_ADDR, 32'hC0);
        rd(TXQ_ADDR, 32'h80);
        @(posedge sys_clk);
        tx_buf_ack <= 1'h1;
        @(posedge sys_clk);
        tx_buf_ack <= 1'h0;
        tx_frame_done <= 1'h1;
        @(posedge sys_clk);
        tx_frame_done <= 1'h0;
        repeat (40) @(posedge sys_clk);
        chk(u_desc_mem_model.mem[33], 32'h8000_8014);
        rd(TXSTAT_ADDR, 32'h1);
        u_desc_mem_model.mem[33] = 32'h0014;
        wr(CTRL_ADDR, 32'h0);
        tx_start;
        @(posedge sys_clk);
        tx_buf_ack <= 1'h1;
        @(posedge sys_clk);
        tx_buf_ack <= 1'h0;
        wait (tx_error_out === 1'h1);
        rd(TXSTAT_ADDR, 32'h11);
        wr(CTRL_ADDR, 32'h208);
        wait (tx_buf_valid === 1'h1);
        #1 chk({tx_buf_first, tx_buf_addr[30:0]}, 32'h8000_0300);
        end_of_test;
    end
endmodule
